// *** sba_consts.svh ***
// constants for the sdram burst access link
`ifndef SBA_CONSTS_SVH
`define SBA_CONSTS_SVH
`define SBA_ADDR_W 12
`define SBA_DATA_W 16
`define SBA_COL_W 8
`define SBA_ROW_W 11
`define SBA_PRECHARGE_ALL_BIT 10
`define SBA_BANK_SELECT_BIT 11
`define SBA_AUTO_PRECHARGE_BIT 10
`define SBA_FULL_PAGE_LEN 256
`define SBA_READ_MASK_LATENCY 2
`define SBA_WRITE_MASK_LATENCY 0
`define SBA_WRITE_RECOVERY 1
`define SBA_TRP_NS 20
`define SBA_CLK_NS 4
`define SBA_TRP_CYC ((`SBA_TRP_NS + `SBA_CLK_NS - 1) / `SBA_CLK_NS)
`define SBA_TDAL_CYC (2 + `SBA_TRP_CYC)
`define SBA_BL_2 3'h1
`define SBA_BL_4 3'h2
`define SBA_BL_8 3'h3
`define SBA_BL_FULL 3'h7
`endif

// *** sba_pkg.sv ***
// types for the sdram burst access link
package sba_pkg;
    typedef enum logic [3:0] {
        SBA_CMD_NOP = 4'h0,
        SBA_CMD_ACT = 4'h1,
        SBA_CMD_RD = 4'h2,
        SBA_CMD_WR = 4'h3,
        SBA_CMD_PRE = 4'h4,
        SBA_CMD_BST = 4'h5
    } sba_cmd_t;
endpackage : sba_pkg

// *** sba_if.sv ***
// link between sdram controller and device
`timescale 1ns/1ns
`include "sba_consts.svh"
interface sba_if;
    import sba_pkg::*;
    sba_cmd_t cmd;
    logic [`SBA_ADDR_W-1:0] addr;
    logic upper_byte_mask;
    logic lower_byte_mask;
    logic [`SBA_DATA_W-1:0] dqCtl;
    logic dqCtlOeN;
    logic [`SBA_DATA_W-1:0] dqDev;
    logic [1:0] dqDevOeN;
    modport dev (input cmd, addr, upper_byte_mask, lower_byte_mask, dqCtl, dqCtlOeN,
        output dqDev, dqDevOeN);
    modport ctl (output cmd, addr, upper_byte_mask, lower_byte_mask, dqCtl, dqCtlOeN,
        input dqDev, dqDevOeN);
endinterface : sba_if

// *** sba_device.sv ***
// sdram device end: burst column access with auto-precharge
// Overview of operation
// - bursts 2/4/8 wrap, sequential or interleaved
// - full page 256 sequential, wraps forever
// - precharge bit chooses one or both banks
// - bank bit picks bank, row in 0..10
// - column bits 0..7, bit10 autoprecharge, bit11 bank
// - read data after cas latency, then per clock
// - drivers on at latency minus one, off after
// - controller stops full-page reads by burst stop
// - read byte mask acts two clocks later
// - controller activates bank before column commands
// - first write word taken with command
// - write ends after burst length; full page stops
// - controller waits write recovery before precharge
// - write byte mask acts same clock
// - read autoprecharge closes bank after burst
// - read precharge leads last beat by cl-1
// - controller waits trp after internal precharge
// - autoprecharge ignored in full page
// - write autoprecharge closes bank after burst
// - write precharge starts clock after last word
// - controller waits two clocks plus trp
// - explicit precharge one clock after last word
// - upper mask bits 15..8, lower 7..0
`timescale 1ns/1ns
`include "sba_consts.svh"
module sba_device #(
    parameter int ROWS = 2048,
    parameter int COLS = 256
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [2:0] burstLen,
    input wire logic interleaved,
    input wire logic casLat3,
    sba_if.dev link,
    output logic [1:0] bankOpen_q,
    output logic [1:0] autoPre_q
);
    import sba_pkg::*;
    initial begin
        if (COLS != `SBA_FULL_PAGE_LEN) $error("sba_device: COLS must be 256");
    end
    // small behavioural store: one open row per bank, a page each
    logic [`SBA_DATA_W-1:0] mem [0:1][0:COLS-1];
    logic [`SBA_ROW_W-1:0] row_q [0:1];

    function automatic logic [7:0] beatCol(input logic [7:0] s, input logic [7:0] n,
        input logic [2:0] bl, input logic il);
        logic [7:0] m;
        m = (bl == `SBA_BL_2) ? 8'h01 : (bl == `SBA_BL_4) ? 8'h03 :
            (bl == `SBA_BL_8) ? 8'h07 : 8'hFF;
        if (il && bl != `SBA_BL_FULL)
            beatCol = (s & ~m) | ((s ^ n) & m);
        else
            beatCol = (s & ~m) | ((s + n) & m);
    endfunction : beatCol

    wire [7:0] burstLast = (burstLen == `SBA_BL_2) ? 8'h01 : (burstLen == `SBA_BL_4) ? 8'h03 :
        (burstLen == `SBA_BL_8) ? 8'h07 : (burstLen == `SBA_BL_FULL) ? 8'hFF : 8'h00;
    wire fullPage = burstLen == `SBA_BL_FULL;
    wire cmdBank = link.addr[`SBA_BANK_SELECT_BIT];
    wire [7:0] cmdCol = link.addr[`SBA_COL_W-1:0];
    wire cmdAuto = link.addr[`SBA_AUTO_PRECHARGE_BIT] && !fullPage;
    wire isRd = link.cmd == SBA_CMD_RD;
    wire isWr = link.cmd == SBA_CMD_WR;

    // internal burst engine
    logic rdAct_q, wrAct_q, bBank_q, bAuto_q;
    logic [7:0] bStart_q, bCnt_q;
    wire [7:0] curCol = beatCol(bStart_q, bCnt_q, burstLen, interleaved);
    wire lastBeat = (bCnt_q == burstLast) && !fullPage;
    wire stop = link.cmd == SBA_CMD_BST || link.cmd == SBA_CMD_PRE;
    wire [1:0] wrKeep = {~link.upper_byte_mask, ~link.lower_byte_mask};

    // read data pipe: stage 0 is filled at the access edge (beat 0 on the command edge),
    // the pin register adds one more, so stage cl-2 feeds the pins for cl clocks of latency
    logic [`SBA_DATA_W-1:0] rdPipe_q [0:2];
    logic [2:0] vPipe_q;
    logic [1:0] mask1_q, mask2_q;
    wire [1:0] lat = casLat3 ? 2'h1 : 2'h0;
    wire outValid = vPipe_q[lat];
    wire [`SBA_DATA_W-1:0] outData = rdPipe_q[lat];
    // precharge lead: last beat internal, output lat+1 clocks later -> lead cl-1
    wire rdPreNow = rdAct_q && lastBeat && bAuto_q;
    logic wrPre_q;
    logic wrPreBank_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdAct_q <= 1'b0;
            wrAct_q <= 1'b0;
            bBank_q <= 1'b0;
            bAuto_q <= 1'b0;
            bStart_q <= 8'h00;
            bCnt_q <= 8'h00;
        end else if (isRd || isWr) begin
            rdAct_q <= isRd && !(fullPage ? 1'b0 : burstLast == 8'h00);
            wrAct_q <= isWr && !(fullPage ? 1'b0 : burstLast == 8'h00);
            bBank_q <= cmdBank;
            bAuto_q <= cmdAuto;
            bStart_q <= cmdCol;
            bCnt_q <= 8'h01; // beat 0 accessed on the command edge
        end else if (stop || ((rdAct_q || wrAct_q) && lastBeat)) begin
            rdAct_q <= 1'b0;
            wrAct_q <= 1'b0;
        end else if (rdAct_q || wrAct_q) begin
            bCnt_q <= bCnt_q + 8'h01;
        end
    end

    // write storage, zero input and mask latency
    wire [7:0] wCol = (isWr || isRd) ? cmdCol : curCol;
    wire wBank = (isWr || isRd) ? cmdBank : bBank_q;
    wire wEn = isWr || (wrAct_q && !stop);
    wire rEn = isRd || (rdAct_q && !stop && !isWr);
    always_ff @(posedge clk) begin
        if (wEn && wrKeep[0]) mem[wBank][wCol][7:0] <= link.dqCtl[7:0];
        if (wEn && wrKeep[1]) mem[wBank][wCol][15:8] <= link.dqCtl[15:8];
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            vPipe_q <= 3'h0;
            mask1_q <= 2'h3;
            mask2_q <= 2'h3;
            wrPre_q <= 1'b0;
            wrPreBank_q <= 1'b0;
        end else begin
            vPipe_q <= {vPipe_q[1:0], rEn};
            mask1_q <= {link.upper_byte_mask, link.lower_byte_mask};
            mask2_q <= mask1_q;
            wrPre_q <= wrAct_q && lastBeat && bAuto_q && !stop;
            wrPreBank_q <= bBank_q;
        end
    end
    always_ff @(posedge clk) begin
        rdPipe_q[0] <= mem[wBank][wCol];
        rdPipe_q[1] <= rdPipe_q[0];
        rdPipe_q[2] <= rdPipe_q[1];
    end

    // output drivers: enable low while driving; mask counted two clocks from pin
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            link.dqDevOeN <= 2'h3;
            link.dqDev <= 16'h0000;
        end else begin
            link.dqDevOeN <= outValid ? mask1_q : 2'h3;
            link.dqDev <= outData;
        end
    end

    // bank state and auto-precharge status
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bankOpen_q <= 2'h0;
            autoPre_q <= 2'h0;
        end else begin
            if (link.cmd == SBA_CMD_ACT) begin
                bankOpen_q[cmdBank] <= 1'b1;
                row_q[cmdBank] <= link.addr[`SBA_ROW_W-1:0];
            end else if (link.cmd == SBA_CMD_PRE) begin
                if (link.addr[`SBA_PRECHARGE_ALL_BIT]) bankOpen_q <= 2'h0;
                else bankOpen_q[cmdBank] <= 1'b0;
            end
            if ((isRd || isWr) && cmdAuto) autoPre_q[cmdBank] <= 1'b1;
            if (rdPreNow) begin
                bankOpen_q[bBank_q] <= 1'b0;
                autoPre_q[bBank_q] <= 1'b0;
            end
            if (wrPre_q) begin
                bankOpen_q[wrPreBank_q] <= 1'b0;
                autoPre_q[wrPreBank_q] <= 1'b0;
            end
        end
    end
endmodule : sba_device

// *** sba_controller.sv ***
// sdram controller end: issues one command per user request
`timescale 1ns/1ns
`include "sba_consts.svh"
module sba_controller (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic reqValid,
    input wire logic [3:0] reqCmd,
    input wire logic [`SBA_ADDR_W-1:0] reqAddr,
    input wire logic [`SBA_DATA_W-1:0] reqData,
    input wire logic [1:0] reqMask,
    input wire logic reqDrive,
    sba_if.ctl link,
    output logic [`SBA_DATA_W-1:0] rdData_q,
    output logic [1:0] rdValid_q
);
    import sba_pkg::*;
    logic [`SBA_DATA_W-1:0] s1_q, s2_q;
    logic [1:0] v1_q, v2_q;
    // user sequences commands: activate first, recovery, bursts stops
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            link.cmd <= SBA_CMD_NOP;
            link.addr <= 12'h000;
            link.upper_byte_mask <= 1'b1;
            link.lower_byte_mask <= 1'b1;
            link.dqCtl <= 16'h0000;
            link.dqCtlOeN <= 1'b1;
        end else begin
            link.cmd <= reqValid ? sba_cmd_t'(reqCmd) : SBA_CMD_NOP;
            link.addr <= reqAddr;
            link.upper_byte_mask <= reqMask[1];
            link.lower_byte_mask <= reqMask[0];
            link.dqCtl <= reqData;
            link.dqCtlOeN <= !reqDrive;
        end
    end
    // device output is a pin: two stages before use
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            v1_q <= 2'h0;
            v2_q <= 2'h0;
            rdValid_q <= 2'h0;
        end else begin
            v1_q <= ~link.dqDevOeN;
            v2_q <= v1_q;
            rdValid_q <= v2_q;
        end
        s1_q <= link.dqDev;
        s2_q <= s1_q;
        rdData_q <= s2_q;
    end
endmodule : sba_controller

// *** sba_burst_monitor.sv ***
// link assertions for the sdram burst access ends
`timescale 1ns/1ns
`include "sba_consts.svh"
module sba_burst_monitor
    import sba_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire sba_cmd_t cmd,
    input wire logic [`SBA_ADDR_W-1:0] addr,
    input wire logic upper_byte_mask,
    input wire logic [1:0] dqDevOeN,
    input wire logic casLat3,
    input wire logic [2:0] burstLen,
    input wire logic [1:0] bankOpen_q
);
    wire logic bankSel = addr[`SBA_BANK_SELECT_BIT];
    wire logic bit10 = addr[`SBA_PRECHARGE_ALL_BIT];
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_rd4;
        cmd == SBA_CMD_RD && burstLen == `SBA_BL_4 && !casLat3;
    endsequence
    sequence s_beats4;
        (dqDevOeN != 2'b11) [*4] ##1 dqDevOeN == 2'b11;
    endsequence
    a_act_opens_bank: assert property (cmd == SBA_CMD_ACT |=> bankOpen_q[$past(bankSel)])
        else $error("bank not opened");
    a_pre_both_banks: assert property (cmd == SBA_CMD_PRE && bit10 |=> bankOpen_q == 2'b00)
        else $error("banks left open");
    a_pre_one_bank: assert property (cmd == SBA_CMD_PRE && !bit10 |=> !bankOpen_q[$past(bankSel)])
        else $error("bank left open");
    a_read_burst_beats: assert property (s_rd4 |-> ##2 s_beats4)
        else $error("read beats misplaced");
    a_read_mask_lag: assert property (upper_byte_mask |-> ##2 dqDevOeN[1])
        else $error("masked lane driven");
    a_write_auto_close: assert property (cmd == SBA_CMD_WR && bit10 && !bankSel
        && burstLen == `SBA_BL_4 |-> ##4 bankOpen_q[0] ##[1:3] !bankOpen_q[0])
        else $error("write precharge mistimed");
    a_read_auto_close: assert property (s_rd4 ##0 (bit10 && !bankSel)
        |-> ##2 bankOpen_q[0] ##[1:4] !bankOpen_q[0])
        else $error("read precharge mistimed");
    a_full_page_keep: assert property (cmd == SBA_CMD_WR && bit10 && !bankSel
        && burstLen == `SBA_BL_FULL |=> bankOpen_q[0] [*8])
        else $error("full page closed bank");
endmodule : sba_burst_monitor

// *** sdram_burst_access_autoprecharge_test.sv ***
// bench: both link ends against a behavioural memory
`timescale 1ns/1ns
`include "sba_consts.svh"
module sdram_burst_access_autoprecharge_test
    import sba_pkg::*;
();
    logic clk = 1'b0, sys_rst = 1'b1, interleaved = 1'b0, casLat3 = 1'b0;
    logic reqValid = 1'b0, reqDrive = 1'b0;
    logic [2:0] burstLen = `SBA_BL_FULL;
    logic [3:0] reqCmd = 4'h0;
    logic [11:0] reqAddr = 12'h000;
    logic [15:0] reqData = 16'h0000;
    logic [1:0] reqMask = 2'h0, bankOpen_q;
    logic [31:0] seed = 32'h00013487;
    int err_total = 0, comparisons = 0, cyc = 0;
    logic [15:0] mem [512];
    logic [15:0] q [$];
    sba_if lnk();
    sba_device sba_device_i (.clk, .sys_rst, .burstLen, .interleaved, .casLat3,
        .link(lnk.dev), .bankOpen_q, .autoPre_q());
    sba_controller sba_controller_i (.clk, .sys_rst, .reqValid, .reqCmd, .reqAddr, .reqData,
        .reqMask, .reqDrive, .link(lnk.ctl), .rdData_q(), .rdValid_q());
    sba_burst_monitor sba_burst_monitor_i (.clk, .sys_rst, .cmd(lnk.cmd), .addr(lnk.addr),
        .upper_byte_mask(lnk.upper_byte_mask), .dqDevOeN(lnk.dqDevOeN), .casLat3,
        .burstLen, .bankOpen_q);
    always #2 clk = ~clk;
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    function automatic int colAt(int s, int k);
        int w = burstLen == `SBA_BL_FULL ? 256 : 1 << burstLen;
        if (w == 256)
            return (s + k) % 256;
        return s - s % w + (interleaved ? (s % w) ^ k : (s % w + k) % w);
    endfunction : colAt
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic close_out();
        $display("mismatches %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : close_out
    task automatic req(input logic [3:0] c, input logic [11:0] a, input logic [15:0] d,
            input logic [1:0] m, input logic dr);
        @(posedge clk);
        reqValid <= 1'b1;
        reqCmd <= c;
        reqAddr <= a;
        reqData <= d;
        reqMask <= m;
        reqDrive <= dr;
    endtask : req
    // masks of at most one lane, so every read beat still shows on at least one lane
    task automatic idle(input int n);
        repeat (n) req(SBA_CMD_NOP, 12'h000, 16'h0000, 2'(rnd() % 3), 1'b0);
    endtask : idle
    task automatic wrb(input logic b, input logic [7:0] s, input logic au, input int n,
            input logic mz);
        logic [15:0] d;
        logic [1:0] m;
        for (int k = 0; k < n; k++) begin
            d = 16'(rnd());
            m = mz ? 2'(rnd()) : 2'h0;
            if (!m[0]) mem[{b, 8'(colAt(s, k))}][7:0] = d[7:0];
            if (!m[1]) mem[{b, 8'(colAt(s, k))}][15:8] = d[15:8];
            req(k ? SBA_CMD_NOP : SBA_CMD_WR, {b, au, 2'h0, s}, d, m, 1'b1);
        end
    endtask : wrb
    task automatic rdb(input logic b, input logic [7:0] s, input logic au, input int n);
        for (int k = 0; k < n; k++) q.push_back(mem[{b, 8'(colAt(s, k))}]);
        req(SBA_CMD_RD, {b, au, 2'h0, s}, 16'h0000, 2'h0, 1'b0);
        idle(n + 8);
    endtask : rdb
    // beats past the expected list (full page wrap before the stop) are ignored
    always @(posedge clk) begin
        if (!sys_rst && lnk.dqDevOeN != 2'b11 && q.size() > 0) begin
            for (int i = 0; i < 2; i++)
                if (!lnk.dqDevOeN[i]) check({8'h00, lnk.dqDev[i*8+:8]}, {8'h00, q[0][i*8+:8]});
            void'(q.pop_front());
        end
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            close_out();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        for (int b = 0; b < 2; b++) begin
            req(SBA_CMD_ACT, {b[0], 11'(rnd())}, 16'h0000, 2'h0, 1'b0);
            idle(2);
            wrb(b[0], 8'(rnd()), 1'b1, 256, 1'b0);
            req(SBA_CMD_BST, 12'h000, 16'h0000, 2'h0, 1'b0);
            idle(8);
            check({15'h0000, bankOpen_q[b]}, 16'h0001);
            rdb(b[0], 8'(rnd()), 1'b0, 260);
            req(SBA_CMD_BST, 12'h000, 16'h0000, 2'h0, 1'b0);
            idle(8);
            check(16'(q.size()), 16'h0000);
        end
        req(SBA_CMD_PRE, 12'h800, 16'h0000, 2'h0, 1'b0);
        idle(3);
        check({14'h0000, bankOpen_q}, 16'h0001);
        req(SBA_CMD_ACT, 12'hC00, 16'h0000, 2'h0, 1'b0);
        idle(3);
        check({14'h0000, bankOpen_q}, 16'h0003);
        req(SBA_CMD_PRE, 12'h400, 16'h0000, 2'h0, 1'b0);
        idle(3);
        check({14'h0000, bankOpen_q}, 16'h0000);
        for (int i = 0; i < 24; i++) begin
            burstLen <= 3'(i % 3 + 1);
            interleaved <= 1'(i / 3 % 2);
            casLat3 <= 1'(i / 6 % 2);
            req(SBA_CMD_ACT, {i[0], 11'(rnd())}, 16'h0000, 2'h0, 1'b0);
            idle(2);
            wrb(i[0], 8'(rnd()), i[1], 1 << (i % 3 + 1), 1'b1);
            idle(8);
            check({15'h0000, bankOpen_q[i[0]]}, {15'h0000, !i[1]});
            req(SBA_CMD_ACT, {i[0], 11'(rnd())}, 16'h0000, 2'h0, 1'b0);
            idle(2);
            rdb(i[0], 8'(rnd()), !i[1], 1 << (i % 3 + 1));
            check({15'h0000, bankOpen_q[i[0]]}, {15'h0000, i[1]});
        end
        close_out();
    end
endmodule : sdram_burst_access_autoprecharge_test
